// >>> bsg_cfg.svh
// offsets, field positions, reset values and timing counts of the bitstream security gate
`ifndef BSG_CFG_SVH
`define BSG_CFG_SVH

// ***************************************************
// register offsets (byte addresses, one word each)
// ***************************************************
`define BSG_ADDR_W 4
`define BSG_OFS_CTRL 4'h0
`define BSG_OFS_STATUS 4'h4
`define BSG_OFS_KEYPROG 4'h8
`define BSG_OFS_COUNT 4'hC

// ***************************************************
// control register fields
// ***************************************************
`define BSG_CTRL_GO 0
`define BSG_CTRL_ENC 1
`define BSG_CTRL_CMP 2
`define BSG_CTRL_SCH_LO 4
`define BSG_CTRL_SCH_HI 6
`define BSG_CTRL_RST 8'h00

// ***************************************************
// key programming register fields
// ***************************************************
`define BSG_KP_REQ 0
`define BSG_KP_VOL 1

// ***************************************************
// datapath and timing
// ***************************************************
`define BSG_DATA_W 8
`define BSG_FIFO_DEPTH 4
`define BSG_FPP_RATIO 3'h4
`define BSG_CNT_W 16

`endif

// >>> bsg_fifo.sv
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module bsg_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // storage words
  logic [AW-1:0] wr_ptr;  // next slot to fill
  logic [AW-1:0] rd_ptr;  // oldest word
  logic [AW:0] fill;  // words held
  logic push;  // word taken in
  logic pop;  // word handed out

  assign wr_ready = (fill != (AW+1)'(DEPTH));
  assign rd_valid = (fill != '0);
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  assign rd_data = mem[rd_ptr];

  // storage; no reset needed since empty words are never read out
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= wr_data;
    end
  end

  // pointers wrap, depth is a power of two
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + AW'(1);
      end
    end
  end

  // fill level, push and pop may meet in one cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fill <= '0;
    end
    else if (push && !pop)
    begin
      fill <= fill + (AW+1)'(1);
    end
    else if (pop && !push)
    begin
      fill <= fill - (AW+1)'(1);
    end
  end
endmodule

// >>> bsg_gate.sv
// bitstream security gate: decides whether a configuration load is accepted and routes it
//
// Overview of operation
// - no key: reject encrypted, accept plain
// - key, tamper clear: accept encrypted and plain
// - key, tamper set: accept only encrypted bitstreams
// - tamper set never blocks a new load
// - erased volatile key rejects encrypted; volatile reprogram
// - boundary scan: plain only, never decrypt
// - encrypted allowed on all five non-scan schemes
// - decrypt first, then feed the decompressor
// - serial schemes run unthrottled; parallel engaged paced
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "bsg_cfg.svh"
module bsg_gate
  import bsg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [`BSG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic config_clock,
  input wire logic [1:0] key_kind_pin,
  input wire logic tamper_pin,
  input wire logic key_erased_pin,
  input wire logic [`BSG_DATA_W-1:0] in_data,
  input wire logic in_valid,
  input wire logic in_last,
  output logic in_ready,
  output logic [`BSG_DATA_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_decrypt,
  output logic out_decompress,
  output logic out_chain,
  output logic key_prog_grant
);

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [4:0] pin_raw;  // config clock, key kind, tamper, erased
  logic [4:0] pin_s1;  // first stage, read only by the second
  logic [4:0] pin_s2;
  logic [4:0] pin_s3;
  logic [4:0] pin_q;  // value taken once the second and third stages agree
  assign pin_raw = {config_clock, key_kind_pin, tamper_pin, key_erased_pin};

  // three-stage chain, a bit changes only when stages two and three match
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
      pin_s3 <= 5'h00;
      pin_q <= 5'h00;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < 5; i++)
      begin
        if (pin_s2[i] == pin_s3[i])
        begin
          pin_q[i] <= pin_s3[i];
        end
      end
    end
  end

  logic cclk_q;  // filtered config clock level
  logic cclk_prev;  // last level, for edge finding
  logic cclk_rise;  // one-cycle pulse per config clock rising edge
  bsg_key_t key_kind;  // decoded key state, illegal code reads as no key
  logic tamper;
  logic erased;
  assign cclk_q = pin_q[4];
  assign tamper = pin_q[1];
  assign erased = pin_q[0];
  assign key_kind = (pin_q[3:2] == 2'h3) ? BSG_KEY_NONE : bsg_key_t'(pin_q[3:2]);
  assign cclk_rise = cclk_q && !cclk_prev;

  // ***************************************************
  // register bus
  // ***************************************************
  logic [7:0] ctrl;  // last written control byte
  logic go;  // one-cycle start request
  logic kp_req;  // key programming request strobe
  assign go = reg_wr && (reg_addr == `BSG_OFS_CTRL) && reg_wdata[`BSG_CTRL_GO];
  assign kp_req = reg_wr && (reg_addr == `BSG_OFS_KEYPROG) && reg_wdata[`BSG_KP_REQ];

  // control holds scheme and header flags, go bit self clears
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= `BSG_CTRL_RST;
    end
    else if (reg_wr && reg_addr == `BSG_OFS_CTRL)
    begin
      ctrl <= {reg_wdata[7:1], 1'b0};
    end
  end

  // ***************************************************
  // load sequencer
  // ***************************************************
  bsg_state_t state;
  bsg_state_t next_state;
  logic [2:0] run_scheme;  // scheme captured at start
  logic run_enc;  // bitstream declared encrypted
  logic run_cmp;  // bitstream declared compressed
  logic verdict;  // combinational accept decision in check
  logic enc_scheme_ok;  // scheme can carry an encrypted stream
  logic key_usable;  // a key able to decrypt is present
  logic start_ok;  // a new load may start
  logic word_in;  // word taken from the host
  logic [`BSG_CNT_W-1:0] word_cnt;  // words taken this load

  assign start_ok = (state == BSG_ST_IDLE) || (state == BSG_ST_DONE) || (state == BSG_ST_REJECT);

  // scheme list for encrypted loads, scan is excluded
  always_comb
  begin
    enc_scheme_ok = 1'b0;
    unique case (run_scheme)
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4: enc_scheme_ok = 1'b1;
      default: enc_scheme_ok = 1'b0;  // scan and illegal codes
    endcase
  end

  // an erased volatile key is as good as none for decryption
  assign key_usable = (key_kind == BSG_KEY_OTP) || (key_kind == BSG_KEY_VOLATILE && !erased);

  // accept decision
  always_comb
  begin
    verdict = 1'b0;
    if (run_scheme > 3'h5)
    begin
      verdict = 1'b0;  // unknown scheme never loads
    end
    else if (run_enc)
    begin
      // decryption needs a live key and a scheme that can reach the engine
      verdict = key_usable && enc_scheme_ok;
    end
    else
    begin
      // plain loads fall through unless tamper protection is on with a key
      verdict = !(tamper && key_kind != BSG_KEY_NONE);
    end
  end

  // next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      BSG_ST_IDLE, BSG_ST_DONE, BSG_ST_REJECT:
      begin
        // tamper protection never locks out a restart
        if (go)
        begin
          next_state = BSG_ST_CHECK;
        end
      end
      BSG_ST_CHECK:
      begin
        next_state = verdict ? BSG_ST_LOAD : BSG_ST_REJECT;
      end
      BSG_ST_LOAD:
      begin
        if (word_in && in_last)
        begin
          next_state = BSG_ST_DRAIN;
        end
      end
      BSG_ST_DRAIN:
      begin
        if (!out_valid)
        begin
          next_state = BSG_ST_DONE;
        end
      end
      default: next_state = BSG_ST_IDLE;  // codes 6 and 7 recover
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= BSG_ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // capture the load description at start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      run_scheme <= 3'h0;
      run_enc <= 1'b0;
      run_cmp <= 1'b0;
    end
    else if (go && start_ok)
    begin
      run_scheme <= reg_wdata[`BSG_CTRL_SCH_HI:`BSG_CTRL_SCH_LO];
      run_enc <= reg_wdata[`BSG_CTRL_ENC];
      run_cmp <= reg_wdata[`BSG_CTRL_CMP];
    end
  end

  // ***************************************************
  // engine routing
  // ***************************************************
  // decided in check, held through the load so the engines see a steady route
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_decrypt <= 1'b0;
      out_decompress <= 1'b0;
      out_chain <= 1'b0;
    end
    else if (state == BSG_ST_CHECK)
    begin
      // scan never reaches the decryptor, verdict already refused it
      out_decrypt <= verdict && run_enc && run_scheme != 3'h5;
      out_decompress <= verdict && run_cmp;
      // on encrypted loads the decompressor reads the decryptor output, never the raw stream
      out_chain <= verdict && run_enc && run_cmp;
    end
    else if (state == BSG_ST_DONE || state == BSG_ST_REJECT)
    begin
      out_decrypt <= 1'b0;
      out_decompress <= 1'b0;
      out_chain <= 1'b0;
    end
  end

  // ***************************************************
  // word pacing
  // ***************************************************
  logic paced;  // parallel load with an engine engaged
  logic [2:0] edge_cnt;  // config clock edges since the last word
  logic pace_ok;  // enough edges seen for one more word
  logic fifo_ready;
  assign paced = (run_scheme == 3'h0) && (run_enc || run_cmp);
  // serial schemes are never paced; they take a word whenever one is offered and the buffer has room
  assign pace_ok = !paced || (edge_cnt >= `BSG_FPP_RATIO);
  assign in_ready = (state == BSG_ST_LOAD) && fifo_ready && pace_ok;
  assign word_in = in_valid && in_ready;

  // edge counter, saturates at the ratio and restarts per word
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cclk_prev <= 1'b0;
      edge_cnt <= 3'h0;
    end
    else
    begin
      cclk_prev <= cclk_q;
      if (state != BSG_ST_LOAD || word_in)
      begin
        edge_cnt <= {2'h0, cclk_rise && state == BSG_ST_LOAD};
      end
      else if (cclk_rise && edge_cnt < `BSG_FPP_RATIO)
      begin
        edge_cnt <= edge_cnt + 3'h1;
      end
    end
  end

  // words counted per load for software
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      word_cnt <= 16'h0000;
    end
    else if (state == BSG_ST_CHECK)
    begin
      word_cnt <= 16'h0000;
    end
    else if (word_in)
    begin
      word_cnt <= word_cnt + 16'h0001;
    end
  end

  // the buffer lets the engines stall without losing host words
  bsg_fifo #(.WIDTH(`BSG_DATA_W), .DEPTH(`BSG_FIFO_DEPTH)) u_fifo
  (
    .clk(clk),
    .rst(rst),
    .wr_data(in_data),
    .wr_valid(in_valid && (state == BSG_ST_LOAD) && pace_ok),
    .wr_ready(fifo_ready),
    .rd_data(out_data),
    .rd_valid(out_valid),
    .rd_ready(out_ready)
  );

  // ***************************************************
  // key reprogramming
  // ***************************************************
  logic kp_denied;  // last request was refused
  // only a volatile-mode request with tamper clear is let through
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      key_prog_grant <= 1'b0;
      kp_denied <= 1'b0;
    end
    else
    begin
      key_prog_grant <= kp_req && reg_wdata[`BSG_KP_VOL] && !tamper;
      if (kp_req)
      begin
        kp_denied <= !(reg_wdata[`BSG_KP_VOL] && !tamper);
      end
    end
  end

  // ***************************************************
  // register read
  // ***************************************************
  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 32'h00000000;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `BSG_OFS_CTRL: reg_rdata <= {24'h000000, ctrl};
        `BSG_OFS_STATUS: reg_rdata <= {19'h00000, kp_denied, erased, tamper, key_kind,
                                       out_chain, out_decompress, out_decrypt,
                                       state == BSG_ST_REJECT, state == BSG_ST_DONE, state};
        `BSG_OFS_COUNT: reg_rdata <= {16'h0000, word_cnt};
        default: reg_rdata <= 32'h00000000;  // unmapped and write-only
      endcase
    end
    else
    begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_check_enc;
    state == BSG_ST_CHECK && run_enc;
  endsequence
  sequence s_check_plain;
    state == BSG_ST_CHECK && !run_enc && run_scheme <= 3'h5;
  endsequence

  a_nokey_enc_reject: assert property (s_check_enc ##0 key_kind == BSG_KEY_NONE |=> state == BSG_ST_REJECT)
    else $error("encrypted load accepted without a key");
  a_keyed_both_ok: assert property ((s_check_enc ##0 key_usable && enc_scheme_ok && !tamper
    or s_check_plain ##0 !tamper) |=> state == BSG_ST_LOAD)
    else $error("keyed load refused with tamper clear");
  a_tamper_plain_no: assert property (s_check_plain ##0 tamper && key_kind != BSG_KEY_NONE
    |=> state == BSG_ST_REJECT)
    else $error("plain load accepted under tamper protection");
  a_restart_allowed: assert property (start_ok && go |=> state == BSG_ST_CHECK)
    else $error("new load blocked");
  a_erased_enc_no: assert property (s_check_enc ##0 key_kind == BSG_KEY_VOLATILE && erased
    |=> state == BSG_ST_REJECT ##1 !out_decrypt)
    else $error("encrypted load accepted with erased key");
  a_keyprog_gate: assert property (kp_req |=> key_prog_grant == ($past(reg_wdata[1]) && !$past(tamper)))
    else $error("key programming gate wrong");
  a_fpp_four_edges: assert property (word_in && paced |-> edge_cnt == `BSG_FPP_RATIO)
    else $error("parallel word taken before four clock edges");
  a_scan_no_decrypt: assert property (run_scheme == 3'h5 && state == BSG_ST_LOAD |-> !out_decrypt)
    else $error("decryptor engaged on scan load");
  a_enc_schemes_ok: assert property (s_check_enc ##0 run_scheme < 3'h5 && key_usable
    |=> state == BSG_ST_LOAD ##0 out_decrypt)
    else $error("encrypted load refused on a serial or parallel scheme");
  a_decrypt_first: assert property (out_decrypt && out_decompress |-> out_chain)
    else $error("decompressor not fed from decryptor");
  a_serial_no_stall: assert property (state == BSG_ST_LOAD && !paced && fifo_ready |-> in_ready)
    else $error("serial load throttled");
endmodule

// >>> bsg_host.sv
// behavioural model of the configuration host feeding the gate
`timescale 1ns/1ps
module bsg_host
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic slow,
  input wire logic [7:0] n_words,
  input wire logic [7:0] base,
  input wire logic in_ready,
  output logic config_clock,
  output logic [7:0] in_data,
  output logic in_valid,
  output logic in_last,
  output logic busy
);
  logic [7:0] idx; // words handed over so far
  logic [1:0] wait_q; // idle cycles left in slow mode
  logic cc_phase; // config clock changes level every second cycle

  // word sequencer: a word is held until the gate takes it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      idx <= 8'h00;
      wait_q <= 2'h0;
    end
    else if (start)
    begin
      busy <= 1'b1;
      idx <= 8'h00;
      wait_q <= 2'h0;
    end
    else if (busy && in_valid && in_ready)
    begin
      idx <= idx + 8'h01;
      wait_q <= slow ? 2'h3 : 2'h0;
      busy <= !in_last;
    end
    else if (wait_q != 2'h0)
      wait_q <= wait_q - 2'h1;
  end

  // clock runs only inside a frame; each level is held two cycles so the gate's
  // three-stage filter sees it, which gives one rising edge every four cycles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      config_clock <= 1'b0;
      cc_phase <= 1'b0;
    end
    else if (!busy)
    begin
      config_clock <= 1'b0;
      cc_phase <= 1'b0;
    end
    else
    begin
      cc_phase <= !cc_phase;
      if (cc_phase)
        config_clock <= !config_clock;
    end
  end

  assign in_valid = busy && (wait_q == 2'h0);
  assign in_last = in_valid && (idx == n_words - 8'h01);
  // between words the bus shows the inverse of the last word, never a stale copy
  assign in_data = in_valid ? base + idx : ~(base + idx - 8'h01);
endmodule

// >>> bsg_pkg.sv
// types shared by the bitstream security gate
package bsg_pkg;

  // configuration scheme in use for the current load
  typedef enum logic [2:0]
  {
    BSG_SCH_FAST_PARALLEL_PASSIVE = 3'h0,
    BSG_SCH_PASSIVE_SERIAL = 3'h1,
    BSG_SCH_ACTIVE_SERIAL = 3'h2,
    BSG_SCH_FAST_ACTIVE_SERIAL = 3'h3,
    BSG_SCH_REMOTE_UPDATE = 3'h4,
    BSG_SCH_BOUNDARY_SCAN = 3'h5
  } bsg_scheme_t;

  // programmed key state
  typedef enum logic [1:0]
  {
    BSG_KEY_NONE = 2'h0,
    BSG_KEY_VOLATILE = 2'h1,
    BSG_KEY_OTP = 2'h2
  } bsg_key_t;

  // load sequencer
  typedef enum logic [2:0]
  {
    BSG_ST_IDLE = 3'h0,
    BSG_ST_CHECK = 3'h1,
    BSG_ST_LOAD = 3'h2,
    BSG_ST_DRAIN = 3'h3,
    BSG_ST_DONE = 3'h4,
    BSG_ST_REJECT = 3'h5
  } bsg_state_t;

endpackage

// >>> tb_config_bitstream_security_gate.sv
// self-checking bench of the bitstream security gate
`timescale 1ns/1ps
`include "bsg_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_config_bitstream_security_gate;
  import bsg_pkg::*;
  logic clk, rst, reg_wr, reg_rd, config_clock, tamper_pin, key_erased_pin;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [1:0] key_kind_pin;
  logic [7:0] in_data, out_data, h_n, h_base;
  logic in_valid, in_last, in_ready, out_valid, out_ready, out_decrypt, out_decompress, out_chain;
  logic key_prog_grant, h_start, h_slow, h_busy;
  int err_total, n_checks, cyc, last_acc, min_gap, n_out;

  bsg_gate DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_clock(config_clock), .key_kind_pin(key_kind_pin),
    .tamper_pin(tamper_pin), .key_erased_pin(key_erased_pin), .in_data(in_data), .in_valid(in_valid),
    .in_last(in_last), .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_decrypt(out_decrypt), .out_decompress(out_decompress),
    .out_chain(out_chain), .key_prog_grant(key_prog_grant));
  bsg_host host (.clk(clk), .rst(rst), .start(h_start), .slow(h_slow), .n_words(h_n), .base(h_base),
    .in_ready(in_ready), .config_clock(config_clock), .in_data(in_data), .in_valid(in_valid),
    .in_last(in_last), .busy(h_busy));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // cycle count, timeout, word gap and output order monitor
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      end_of_test();
    end
    if (!rst && in_valid && in_ready)
    begin
      if (last_acc >= 0 && cyc - last_acc < min_gap)
        min_gap = cyc - last_acc;
      last_acc = cyc;
    end
    if (!rst && out_valid && out_ready)
    begin
      `CHK("out_data", h_base + n_out[7:0], out_data)
      n_out++;
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data are taken in the one cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // acceptance worked out from key state, tamper bit and scheme
  function automatic logic acc_f(logic [1:0] k, logic t, logic e, logic en, logic [2:0] sc);
    if (en)
      return (k == 2'h2 || (k == 2'h1 && !e)) && sc <= 3'h4;
    return !(t && (k == 2'h1 || k == 2'h2)) && sc <= 3'h5;
  endfunction

  // one complete load attempt, judged at the ports and in the status register
  task automatic run_load(input logic [1:0] k, input logic t, input logic e, input logic en,
    input logic cm, input logic [2:0] sc, input logic [7:0] n, input logic stl);
    logic acc;
    int i;
    acc = acc_f(k, t, e, en, sc);
    key_kind_pin <= k;
    tamper_pin <= t;
    key_erased_pin <= e;
    repeat (6) @(posedge clk);
    wr(`BSG_OFS_CTRL, {25'h0, sc, 1'b0, cm, en, 1'b1});
    repeat (2) @(posedge clk);
    #1;
    rd(`BSG_OFS_STATUS, v);
    `CHK("state", acc ? 3'h2 : 3'h5, v[2:0])
    if (acc)
    begin
      `CHK("decrypt", en, out_decrypt)
      `CHK("decompress", cm, out_decompress)
      `CHK("chain", en & cm, out_chain)
      last_acc = -1;
      min_gap = 1000;
      n_out = 0;
      h_base <= 8'hA0 + n;
      h_n <= n;
      out_ready <= !stl;
      h_start <= 1'b1;
      @(posedge clk);
      h_start <= 1'b0;
      if (stl)
      begin
        repeat (60) @(posedge clk);
        rd(`BSG_OFS_COUNT, v);
        `CHK("count_full", 32'h4, v)
        `CHK("in_ready_full", 1'b0, in_ready)
        out_ready <= 1'b1;
      end
      // a stale count word must not look like a finished state
      v = 32'h0;
      for (i = 0; i < 200 && v[2:0] !== 3'h4; i++)
        rd(`BSG_OFS_STATUS, v);
      `CHK("done", 3'h4, v[2:0])
      rd(`BSG_OFS_COUNT, v);
      `CHK("count", {24'h0, n}, v)
      `CHK("words_out", int'(n), n_out)
      // four config clock rises per word, the host gives one every four cycles
      if (sc == 3'h0 && (en || cm))
        `CHK("paced", 1'b1, min_gap >= 16)
      else if (!stl)
        `CHK("unpaced", h_slow ? 4 : 1, min_gap)
    end
    else
      `CHK("in_ready_rej", 1'b0, in_ready)
  endtask

  // reset values, unmapped read, control readback
  task automatic t_regs;
    rd(`BSG_OFS_STATUS, v);
    `CHK("status_rst", 32'h0, v)
    rd(`BSG_OFS_COUNT, v);
    `CHK("count_rst", 32'h0, v)
    rd(4'h2, v);
    `CHK("unmapped", 32'h0, v)
    wr(`BSG_OFS_CTRL, 32'h00000016);
    rd(`BSG_OFS_CTRL, v);
    `CHK("ctrl_rb", 32'h16, v)
    rd(`BSG_OFS_STATUS, v);
    `CHK("no_go", 3'h0, v[2:0])
  endtask

  // key reprogram granted only with tamper clear
  task automatic t_keyprog;
    key_kind_pin <= 2'h1;
    tamper_pin <= 1'b0;
    key_erased_pin <= 1'b1;
    repeat (6) @(posedge clk);
    wr(`BSG_OFS_KEYPROG, 32'h3);
    #1 `CHK("grant", 1'b1, key_prog_grant)
    wr(`BSG_OFS_KEYPROG, 32'h1);
    #1 `CHK("no_grant_otp", 1'b0, key_prog_grant)
    tamper_pin <= 1'b1;
    repeat (6) @(posedge clk);
    wr(`BSG_OFS_KEYPROG, 32'h3);
    #1 `CHK("no_grant", 1'b0, key_prog_grant)
    rd(`BSG_OFS_STATUS, v);
    `CHK("denied", 1'b1, v[12])
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    int s;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    key_kind_pin = 2'h0;
    tamper_pin = 1'b0;
    key_erased_pin = 1'b0;
    out_ready = 1'b1;
    h_start = 1'b0;
    h_slow = 1'b0;
    h_n = 8'h1;
    h_base = 8'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    run_load(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1, 8'h3, 1'b0);
    run_load(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2, 8'h3, 1'b0);
    run_load(2'h3, 1'b0, 1'b0, 1'b1, 1'b0, 3'h1, 8'h3, 1'b0);
    run_load(2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 8'h3, 1'b0);
    run_load(2'h2, 1'b0, 1'b0, 1'b1, 1'b0, 3'h1, 8'h3, 1'b0);
    run_load(2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 3'h2, 8'h3, 1'b0);
    run_load(2'h1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h1, 8'h3, 1'b0);
    run_load(2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 3'h3, 8'h3, 1'b0);
    run_load(2'h1, 1'b1, 1'b0, 1'b1, 1'b1, 3'h4, 8'h3, 1'b0);
    run_load(2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 3'h1, 8'h3, 1'b0);
    run_load(2'h1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h1, 8'h3, 1'b0);
    run_load(2'h2, 1'b0, 1'b0, 1'b1, 1'b0, 3'h5, 8'h3, 1'b0);
    run_load(2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 3'h5, 8'h3, 1'b0);
    for (s = 0; s < 5; s++)
      run_load(2'h2, 1'b0, 1'b0, 1'b1, 1'b1, s[2:0], 8'h4, 1'b0);
    run_load(2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 8'h3, 1'b0);
    run_load(2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1, 8'h6, 1'b1);
    h_slow <= 1'b1;
    run_load(2'h2, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2, 8'h3, 1'b0);
    t_keyprog();
    end_of_test();
  end
endmodule
